// ---- ssl_defs.svh ----
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH
// Notes on behaviour
// - frames arrive msb first; each data bit is taken on serial clock rising edge.
// - clock count in a frame picks target: 8 config, 16 reference, 24 counter.
// - registers stay unchanged while bits shift; they update only at frame end.
// - low 13 reference bits are double-buffered; 16-bit frame loads first buffer only.
// - upper 3 reference bits take effect at once when a 16-bit frame ends.
// - a 24-bit frame also copies the first reference buffer into the second.
// - enable-low pulse without clock edges copies first reference buffer to second.
// - no address bits; all bits are data; registers written in any order.
// - in data-out mode the output shifts on each falling serial clock edge.
// - static shift register; any serial clock rate down to dc is tolerated.
// - enable rising edge moves shifted data to the target chosen by length.
// - while enable is high clock edges are ignored and the port stays initialized.
// - after reset the multi-function output defaults to serial data out.
`define SSL_LEN_CFG      6'd8
`define SSL_LEN_REF      6'd16
`define SSL_LEN_CNT      6'd24
`define SSL_LEN_MAX      6'd32
`define SSL_CFG_RESET    8'h00
`define SSL_REF_RESET    16'h0000
`define SSL_CNT_RESET    24'h400000
`define SSL_REF_LO_W     13
`define SSL_SEL_HI_BIT   23
`define SSL_SEL_LO_BIT   22
`endif

// ---- ssl_pkg.sv ----
package ssl_pkg;
   typedef enum logic [1:0] {
      SSL_OUT_PORT = 2'b00,
      SSL_OUT_DATA = 2'b01,
      SSL_OUT_FV   = 2'b10,
      SSL_OUT_FR   = 2'b11
   } ssl_out_mode_t;
   typedef struct packed {
      logic [7:0]  config_reg;
      logic [2:0]  ref_hi;
      logic [12:0] ref_buf1;
      logic [12:0] ref_buf2;
      logic [23:0] counter_reg;
   } ssl_regs_t;
endpackage

// ---- ssl_sync.sv ----
`timescale 1ns/1ps
module ssl_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_stage2;
   always_comb begin
      next_stage1 = async_i;
      next_stage2 = stage1;
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         stage1 <= '1;
         stage2 <= '1;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end
   assign sync_o = stage2;
endmodule

// ---- ssl_loader.sv ----
`timescale 1ns/1ps
`include "ssl_defs.svh"
module ssl_loader (
   input  wire logic               ref_clk_i,
   input  wire logic               reset_i,
   input  wire logic               serial_clk_i,
   input  wire logic               serial_data_i,
   input  wire logic               port_select_n_i,
   input  wire logic               fr_pulse_i,
   input  wire logic               fv_pulse_i,
   output logic                    out_a_o,
   output ssl_pkg::ssl_out_mode_t  out_mode_o,
   output ssl_pkg::ssl_regs_t      regs_o
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [2:0] pins_s;
   ssl_sync #(.WIDTH(3)) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .async_i   ({port_select_n_i, serial_clk_i, serial_data_i}),
      .sync_o    (pins_s)
   );
   logic sel_n_s;
   logic sclk_s;
   logic sdat_s;
   assign sel_n_s = pins_s[2];
   assign sclk_s  = pins_s[1];
   assign sdat_s  = pins_s[0];

   // ****************************************
   // edge detection and shifting
   // ****************************************
   logic        sclk_d;
   logic        sel_n_d;
   logic [31:0] shifter;
   logic [5:0]  edge_cnt;
   logic        out_bit;
   logic        next_sclk_d;
   logic        next_sel_n_d;
   logic [31:0] next_shifter;
   logic [5:0]  next_edge_cnt;
   logic        next_out_bit;
   logic        rise;
   logic        fall;
   logic        frame_end;
   logic        frame_start;
   ssl_pkg::ssl_regs_t    regs;
   ssl_pkg::ssl_regs_t    next_regs;

   assign rise        = sclk_s & ~sclk_d;
   assign fall        = ~sclk_s & sclk_d;
   assign frame_end   = sel_n_s & ~sel_n_d;
   assign frame_start = ~sel_n_s & sel_n_d;

   always_comb begin
      next_sclk_d   = sclk_s;
      next_sel_n_d  = sel_n_s;
      next_shifter  = shifter;
      next_edge_cnt = edge_cnt;
      next_out_bit  = out_bit;
      if (sel_n_s) begin
         next_edge_cnt = 6'd0;
      end else if (frame_start) begin
         next_edge_cnt = 6'd0;
      end else if (rise) begin
         next_shifter = {shifter[30:0], sdat_s};
         if (edge_cnt != 6'h3f) begin
            next_edge_cnt = edge_cnt + 6'd1;
         end
      end else if (fall) begin
         next_out_bit = shifter[23];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sclk_d   <= 1'b1;
         sel_n_d  <= 1'b1;
         shifter  <= 32'h0;
         edge_cnt <= 6'd0;
         out_bit  <= 1'b0;
      end else begin
         sclk_d   <= next_sclk_d;
         sel_n_d  <= next_sel_n_d;
         shifter  <= next_shifter;
         edge_cnt <= next_edge_cnt;
         out_bit  <= next_out_bit;
      end
   end

   // ****************************************
   // register transfer at frame end
   // ****************************************
   always_comb begin
      next_regs = regs;
      if (frame_end) begin
         unique case (edge_cnt)
            `SSL_LEN_CFG: next_regs.config_reg = shifter[7:0];
            `SSL_LEN_REF: begin
               next_regs.ref_hi   = shifter[15:13];
               next_regs.ref_buf1 = shifter[12:0];
            end
            `SSL_LEN_CNT: begin
               next_regs.counter_reg = shifter[23:0];
               next_regs.ref_buf2    = regs.ref_buf1;
            end
            6'd0: next_regs.ref_buf2 = regs.ref_buf1;
            default: next_regs = regs;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         regs.config_reg  <= `SSL_CFG_RESET;
         regs.ref_hi      <= 3'(`SSL_REF_RESET >> `SSL_REF_LO_W);
         regs.ref_buf1    <= 13'(`SSL_REF_RESET);
         regs.ref_buf2    <= 13'(`SSL_REF_RESET);
         regs.counter_reg <= `SSL_CNT_RESET;
      end else begin
         regs <= next_regs;
      end
   end

   // ****************************************
   // multi-function output
   // ****************************************
   ssl_pkg::ssl_out_mode_t mode;
   assign mode = ssl_pkg::ssl_out_mode_t'({regs.counter_reg[`SSL_SEL_HI_BIT],
                                           regs.counter_reg[`SSL_SEL_LO_BIT]});
   logic out_a;
   logic next_out_a;
   always_comb begin
      unique case (mode)
         ssl_pkg::SSL_OUT_PORT: next_out_a = regs.config_reg[1];
         ssl_pkg::SSL_OUT_DATA: next_out_a = out_bit;
         ssl_pkg::SSL_OUT_FV:   next_out_a = fv_pulse_i;
         ssl_pkg::SSL_OUT_FR:   next_out_a = fr_pulse_i;
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         out_a <= 1'b0;
      end else begin
         out_a <= next_out_a;
      end
   end
   assign out_a_o    = out_a;
   assign out_mode_o = mode;
   assign regs_o     = regs;

   // ****************************************
   // checks
   // ****************************************
   property p_hold_mid_frame;
      @(posedge ref_clk_i) disable iff (reset_i)
      !frame_end |=> regs == $past(regs);
   endproperty
   a_hold_mid_frame: assert property (p_hold_mid_frame) else $error("register changed mid frame");

   property p_cfg_load;
      @(posedge ref_clk_i) disable iff (reset_i)
      frame_end && edge_cnt == `SSL_LEN_CFG |=> regs.config_reg == $past(shifter[7:0]);
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");

   property p_ref_buf1_only;
      @(posedge ref_clk_i) disable iff (reset_i)
      frame_end && edge_cnt == `SSL_LEN_REF |=>
         regs.ref_buf1 == $past(shifter[12:0]) && $stable(regs.ref_buf2);
   endproperty
   a_ref_buf1_only: assert property (p_ref_buf1_only) else $error("reference buffer wrong");

   property p_ref_hi;
      @(posedge ref_clk_i) disable iff (reset_i)
      frame_end && edge_cnt == `SSL_LEN_REF |=> regs.ref_hi == $past(shifter[15:13]);
   endproperty
   a_ref_hi: assert property (p_ref_hi) else $error("upper reference bits not applied");

   property p_cnt_copy;
      @(posedge ref_clk_i) disable iff (reset_i)
      frame_end && edge_cnt == `SSL_LEN_CNT |=>
         regs.ref_buf2 == $past(regs.ref_buf1) && regs.counter_reg == $past(shifter[23:0]);
   endproperty
   a_cnt_copy: assert property (p_cnt_copy) else $error("counter frame transfer wrong");

   property p_empty_copy;
      @(posedge ref_clk_i) disable iff (reset_i)
      frame_end && edge_cnt == 6'd0 |=> regs.ref_buf2 == $past(regs.ref_buf1);
   endproperty
   a_empty_copy: assert property (p_empty_copy) else $error("empty pulse did not copy");

   property p_bad_len;
      @(posedge ref_clk_i) disable iff (reset_i)
      frame_end && edge_cnt != 6'd0 && edge_cnt != `SSL_LEN_CFG && edge_cnt != `SSL_LEN_REF
         && edge_cnt != `SSL_LEN_CNT |=> $stable(regs);
   endproperty
   a_bad_len: assert property (p_bad_len) else $error("bad length changed registers");

   property p_idle_cnt;
      @(posedge ref_clk_i) disable iff (reset_i)
      sel_n_s ##1 sel_n_s |-> edge_cnt == 6'd0;
   endproperty
   a_idle_cnt: assert property (p_idle_cnt) else $error("count moved while idle");

   property p_count;
      @(posedge ref_clk_i) disable iff (reset_i)
      !sel_n_s && !frame_start && rise && edge_cnt < 6'd40 |=> edge_cnt == $past(edge_cnt) + 6'd1;
   endproperty
   a_count: assert property (p_count) else $error("edge not counted");

   property p_data_out;
      @(posedge ref_clk_i) disable iff (reset_i)
      mode == ssl_pkg::SSL_OUT_DATA && !sel_n_s && !rise && fall ##1 mode == ssl_pkg::SSL_OUT_DATA
         |=> out_a == $past(shifter[23], 2);
   endproperty
   a_data_out: assert property (p_data_out) else $error("data out wrong");

   property p_shift;
      @(posedge ref_clk_i) disable iff (reset_i)
      !sel_n_s && !frame_start && rise |=> shifter[0] == $past(sdat_s);
   endproperty
   a_shift: assert property (p_shift) else $error("bit not shifted in");

   property p_reset_mode;
      @(posedge ref_clk_i)
      reset_i |=> mode == ssl_pkg::SSL_OUT_DATA;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("reset mode not data out");
endmodule

// ---- ssl_host_model.sv ----
`timescale 1ns/1ps
// ************************************
// host side of the serial load port
// ************************************
module ssl_host_model (
   input  wire logic ref_clk_i,
   output logic      serial_clk_o,
   output logic      serial_data_o,
   output logic      port_select_n_o
);
   initial begin
      serial_clk_o    = 1'b0;
      serial_data_o   = 1'b0;
      port_select_n_o = 1'b1;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask

   // msb first, enable moved only while clock low
   task automatic send(input logic [63:0] bits, input int n);
      port_select_n_o = 1'b0;
      tick(4);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_o = bits[i];
         tick(4);
         serial_clk_o = 1'b1;
         tick(4 + $urandom_range(6));
         serial_clk_o = 1'b0;
         tick(4);
      end
      tick(6);
      port_select_n_o = 1'b1;
      // released data line shows no stale value
      serial_data_o = ~serial_data_o;
      tick(4);
   endtask

   // clock pulses with the port deselected
   task automatic idle_clocks(input int k);
      repeat (k) begin
         serial_clk_o = 1'b1;
         tick(4);
         serial_clk_o = 1'b0;
         tick(4);
      end
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
// ************************************
// self-checking bench
// ************************************
module tb_top;
   logic                   ref_clk_i;
   logic                   reset_i;
   logic                   fr_pulse_i;
   logic                   fv_pulse_i;
   logic                   sclk;
   logic                   sdat;
   logic                   psel_n;
   logic                   out_a_o;
   ssl_pkg::ssl_out_mode_t out_mode_o;
   ssl_pkg::ssl_regs_t     regs_o;
   int                     error_cnt;
   int                     num_checks;
   int                     m_cfg, m_hi, m_b1, m_b2, m_cnt;
   logic [63:0]            bits;
   int                     lens [9] = '{1, 7, 9, 15, 17, 23, 25, 31, 32};
   int                     modes [4] = '{0, 2, 3, 1};

   ssl_host_model i_host (.ref_clk_i(ref_clk_i), .serial_clk_o(sclk), .serial_data_o(sdat),
                          .port_select_n_o(psel_n));
   ssl_loader i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .serial_clk_i(sclk),
                     .serial_data_i(sdat), .port_select_n_i(psel_n), .fr_pulse_i(fr_pulse_i),
                     .fv_pulse_i(fv_pulse_i), .out_a_o(out_a_o), .out_mode_o(out_mode_o),
                     .regs_o(regs_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_regs();
      chk(regs_o.config_reg, m_cfg);
      chk(regs_o.ref_hi, m_hi);
      chk(regs_o.ref_buf1, m_b1);
      chk(regs_o.ref_buf2, m_b2);
      chk(regs_o.counter_reg, m_cnt);
      chk(out_mode_o, m_cnt[23:22]);
   endtask

   task automatic frame(input logic [63:0] b, input int n);
      ssl_pkg::ssl_regs_t snap;
      int                 guard;
      snap  = regs_o;
      guard = 0;
      fork
         i_host.send(b, n);
         begin
            tick(2);
            while (psel_n === 1'b0 && guard < 2000) begin
               chk(regs_o, snap);
               guard++;
               tick(1);
            end
         end
      join
      if (guard >= 2000) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, guard, 2000);
      end
      case (n)
         8: m_cfg = b[7:0];
         16: begin
            m_hi = b[15:13];
            m_b1 = b[12:0];
         end
         24: begin
            m_cnt = b[23:0];
            m_b2  = m_b1;
         end
         0: m_b2 = m_b1;
         default: ;
      endcase
      tick(4);
      check_regs();
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk_i);
      error_cnt++;
      test_done();
   end

   initial begin
      void'($urandom(32'h780a));
      reset_i    = 1'b1;
      fr_pulse_i = 1'b0;
      fv_pulse_i = 1'b0;
      tick(10);
      reset_i = 1'b0;
      tick(4);
      m_cfg = 0; m_hi = 0; m_b1 = 0; m_b2 = 0; m_cnt = 'h400000;
      check_regs();
      $display("test reset done");
      bits = {$urandom, $urandom};
      frame(bits, 33);
      chk(out_a_o, bits[23]);
      $display("test data_out done");
      frame($urandom, 8);
      frame($urandom, 16);
      frame(0, 0);
      frame($urandom, 16);
      frame({2'b01, 22'($urandom)}, 24);
      $display("test load order done");
      foreach (lens[i]) frame({$urandom, $urandom}, lens[i]);
      $display("test bad length done");
      bits[0] = out_a_o;
      i_host.idle_clocks(5);
      tick(4);
      chk(out_a_o, bits[0]);
      check_regs();
      frame($urandom, 8);
      $display("test idle clocks done");
      foreach (modes[i]) begin
         bits = {2'(modes[i]), 22'($urandom)};
         frame(bits, 24);
         repeat (2) begin
            fv_pulse_i = 1'($urandom);
            fr_pulse_i = 1'($urandom);
            tick(6);
            case (modes[i])
               0: chk(out_a_o, m_cfg[1]);
               2: chk(out_a_o, fv_pulse_i);
               3: chk(out_a_o, fr_pulse_i);
               default: chk(out_a_o, bits[23]);
            endcase
         end
      end
      $display("test out modes done");
      test_done();
   end
endmodule
